// *** src/ucrc_ctrl.sv ***
// Added by the designer: the register addresses and the Avalon-MM slave port.
`timescale 1ns/1ps
// Summary of operation
// - Accumulate and check only while Active.
// - Below limit, operate normally in every behaviour.
// - Attach or removal never clears accumulation.
// - Removal then attach restarts emulation below limit.
// - Behaviour write leaves accumulator untouched.
// - Pre-limit behaviour change stored silently.
// - Post-limit behaviour change acts at once.
// - From Ignore: apply new behaviour actions.
// - From Report: apply pairwise transition actions.
// - From Report-and-disconnect: release, re-evaluate or sleep.
// - From Disconnect-and-sleep: alert unless Ignore, re-evaluate unless Report-and-disconnect.
// - Re-evaluate restarts emulation only if pins changed.
// - Disable before limit zeroes accumulator.
// - Disable after limit clears flag, alert, re-evaluates.
// - Clear control zeroes accumulator; accumulation continues.
// - Clear after limit runs behaviour reset actions.
// - Two-bit code: report, rep-disc, sleep, ignore.
// - Report-and-disconnect keeps switches open, states follow.
// - Disconnect-and-sleep ignores control changes.
// - Reset clears flag, releases alert, re-evaluates.
module ucrc_ctrl
(
    // Clock and reset.
    input  wire logic        CLOCK,
    input  wire logic        ARST_N,
    // Avalon-MM slave.
    input  wire logic [3:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic      [1:0]  AVS_RESPONSE,
    // Power state and measurement.
    input  wire logic        ACTIVE_STATE,
    input  wire logic        CHARGE_TICK,
    input  wire logic [15:0] CHARGE_AMOUNT,
    input  wire logic        REMOVAL_EVENT,
    input  wire logic        ATTACH_EVENT,
    input  wire logic        OTHER_ALERT,
    // Host controls.
    input  wire logic        MODE_SELECT_HI,
    input  wire logic        MODE_SELECT_LO,
    input  wire logic        EMULATION_ENABLE,
    input  wire logic        ATTACH_GATE_SELECT,
    input  wire logic        PORT_POWER_ENABLE,
    // Actions.
    output logic             ALERT_N,
    output logic             PORT_SWITCH_BLOCK,
    output logic             BYPASS_BLOCK,
    output logic             EMULATION_REMOVE,
    output logic             EMULATION_RESTART,
    output logic             SLEEP_REQUEST,
    output logic             CONTROLS_FROZEN
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed
    {
        ucrc_pkg::ucrc_bus_e bus;
        logic [31:0]         rdata;
        logic                limit_feature_enable;
        logic [1:0]          limit_behavior_sel;
        logic [31:0]         limit;
        logic [31:0]         accum;
        logic                limit_reached_flag;
        logic                alert;
        logic                sw_block;
        logic                emu_remove;
        logic                sleep;
        logic                restart;
        logic                removed;
    } ucrc_state_s;

    ucrc_state_s state;
    ucrc_state_s next_state;
    ucrc_ctl_if  ctl ();

    logic [4:0] pins;
    assign pins = {MODE_SELECT_HI, MODE_SELECT_LO, EMULATION_ENABLE,
                   ATTACH_GATE_SELECT, PORT_POWER_ENABLE};

    ucrc_pin_snap u_snap
    (
        .CLOCK  (CLOCK),
        .ARST_N (ARST_N),
        .ctl    (ctl)
    );

    assign ctl.pins = pins;

    // ****************************************************************
    // Functions
    // ****************************************************************
    // Behaviour codes decode to their alert and disconnect actions.
    function automatic logic beh_alerts(input logic [1:0] b);
        beh_alerts = (b == ucrc_pkg::BEH_REPORT) || (b == ucrc_pkg::BEH_REPORT_DISC);
    endfunction : beh_alerts

    function automatic logic beh_disconnects(input logic [1:0] b);
        beh_disconnects = (b == ucrc_pkg::BEH_REPORT_DISC) || (b == ucrc_pkg::BEH_DISC_SLEEP);
    endfunction : beh_disconnects

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic        wr_hit;
    logic        rd_hit;
    logic [31:0] ctrl_wd;
    logic        ctrl_wr;
    logic        go_disable;
    logic        go_clear;
    logic        beh_change;
    logic [1:0]  new_beh;
    logic [32:0] sum;
    logic        reeval;
    logic        do_latch;

    always_comb
    begin
        next_state = state;
        next_state.restart = 1'b0;
        wr_hit  = AVS_WRITE && (state.bus == ucrc_pkg::UCRC_IDLE);
        rd_hit  = AVS_READ && (state.bus == ucrc_pkg::UCRC_IDLE);
        ctrl_wr = wr_hit && (AVS_ADDRESS == ucrc_pkg::ADDR_CTRL);
        ctrl_wd = merge({23'h0, 1'b0, 2'h0, state.limit_behavior_sel, 2'h0, 1'b0,
                         state.limit_feature_enable},
                        AVS_WRITEDATA, AVS_BYTEENABLE);
        new_beh    = ctrl_wd[ucrc_pkg::CTRL_BEH_LSB +: 2];
        go_disable = ctrl_wr && state.limit_feature_enable && !ctrl_wd[ucrc_pkg::CTRL_EN_BIT];
        go_clear   = ctrl_wr && ctrl_wd[ucrc_pkg::CTRL_CLR_BIT];
        beh_change = ctrl_wr && (new_beh != state.limit_behavior_sel);
        reeval     = 1'b0;
        do_latch   = 1'b0;
        sum        = {1'b0, state.accum} + {17'h0, CHARGE_AMOUNT};

        // Bus handshake: one wait cycle, then acknowledge.
        case (state.bus)
            ucrc_pkg::UCRC_IDLE:
            begin
                if (AVS_READ || AVS_WRITE)
                begin
                    next_state.bus = ucrc_pkg::UCRC_ACK;
                end
            end
            ucrc_pkg::UCRC_ACK:
            begin
                next_state.bus = ucrc_pkg::UCRC_IDLE;
            end
            default:
            begin
                next_state.bus = ucrc_pkg::UCRC_IDLE;
            end
        endcase

        if (rd_hit)
        begin
            case (AVS_ADDRESS)
                ucrc_pkg::ADDR_CTRL:
                    next_state.rdata = {26'h0, state.limit_behavior_sel, 3'h0,
                                        state.limit_feature_enable};
                ucrc_pkg::ADDR_LIMIT:  next_state.rdata = state.limit;
                ucrc_pkg::ADDR_ACCUM:  next_state.rdata = state.accum;
                ucrc_pkg::ADDR_STATUS:
                    next_state.rdata = {27'h0, state.emu_remove, state.sleep, state.sw_block,
                                        state.alert, state.limit_reached_flag};
                default:               next_state.rdata = 32'h0000_0000;
            endcase
        end

        if (wr_hit && (AVS_ADDRESS == ucrc_pkg::ADDR_LIMIT))
        begin
            next_state.limit = merge(state.limit, AVS_WRITEDATA, AVS_BYTEENABLE);
        end

        // Accumulate only while Active and below limit; attach/removal
        // events are deliberately not consulted here.
        if (state.limit_feature_enable && ACTIVE_STATE && CHARGE_TICK
            && !state.limit_reached_flag)
        begin
            next_state.accum = sum[32] ? 32'hFFFF_FFFF : sum[31:0];
            if (sum >= {1'b0, state.limit})
            begin
                next_state.limit_reached_flag = 1'b1;
                next_state.alert      = beh_alerts(state.limit_behavior_sel);
                next_state.sw_block   = beh_disconnects(state.limit_behavior_sel);
                next_state.emu_remove = beh_disconnects(state.limit_behavior_sel);
                next_state.sleep      = (state.limit_behavior_sel == ucrc_pkg::BEH_DISC_SLEEP);
                do_latch = 1'b1;
            end
        end

        // Removal then attach below the limit restarts emulation.
        if (REMOVAL_EVENT)
        begin
            next_state.removed = 1'b1;
        end
        if (ATTACH_EVENT)
        begin
            next_state.removed = 1'b0;
            if (state.removed && state.limit_feature_enable && !state.limit_reached_flag)
            begin
                next_state.restart = EMULATION_ENABLE;
            end
        end

        if (ctrl_wr)
        begin
            // Stored silently below the limit; accumulator untouched.
            next_state.limit_behavior_sel   = new_beh;
            next_state.limit_feature_enable = ctrl_wd[ucrc_pkg::CTRL_EN_BIT];
        end

        if (beh_change && state.limit_reached_flag)
        begin
            case (state.limit_behavior_sel)
                ucrc_pkg::BEH_IGNORE:
                begin
                    next_state.alert      = (new_beh != ucrc_pkg::BEH_DISC_SLEEP);
                    next_state.sw_block   = beh_disconnects(new_beh);
                    next_state.emu_remove = beh_disconnects(new_beh);
                    next_state.sleep      = (new_beh == ucrc_pkg::BEH_DISC_SLEEP);
                end
                ucrc_pkg::BEH_REPORT:
                begin
                    next_state.alert      = (new_beh == ucrc_pkg::BEH_REPORT_DISC);
                    next_state.sw_block   = beh_disconnects(new_beh);
                    next_state.emu_remove = (new_beh == ucrc_pkg::BEH_DISC_SLEEP);
                    next_state.sleep      = (new_beh == ucrc_pkg::BEH_DISC_SLEEP);
                end
                ucrc_pkg::BEH_REPORT_DISC:
                begin
                    next_state.alert = (new_beh == ucrc_pkg::BEH_REPORT);
                    if (new_beh == ucrc_pkg::BEH_DISC_SLEEP)
                    begin
                        next_state.alert      = 1'b0;
                        next_state.sleep      = 1'b1;
                        next_state.sw_block   = 1'b1;
                        next_state.emu_remove = 1'b1;
                    end
                    else
                    begin
                        reeval = 1'b1;
                    end
                end
                default:
                begin
                    next_state.alert = beh_alerts(new_beh);
                    next_state.sleep = 1'b0;
                    if (new_beh == ucrc_pkg::BEH_REPORT_DISC)
                    begin
                        next_state.sw_block = 1'b1;
                        next_state.emu_remove = 1'b1;
                    end
                    else
                    begin
                        reeval = 1'b1;
                    end
                end
            endcase
        end

        // Disable: below limit zero the accumulator, above it recover.
        if (go_disable)
        begin
            next_state.accum = 32'h0000_0000;
            if (state.limit_reached_flag)
            begin
                next_state.limit_reached_flag = 1'b0;
                next_state.alert = 1'b0;
                reeval = 1'b1;
            end
        end

        // Clear control is self-clearing and never stored.
        if (go_clear)
        begin
            next_state.accum = 32'h0000_0000;
            if (state.limit_reached_flag)
            begin
                next_state.limit_reached_flag = 1'b0;
                if (beh_alerts(state.limit_behavior_sel))
                begin
                    next_state.alert = 1'b0;
                end
                if (beh_disconnects(state.limit_behavior_sel))
                begin
                    reeval = 1'b1;
                end
            end
        end

        // Re-evaluation: switches released, emulation restarted only when the
        // pins moved since the limit was reached.
        if (reeval && !(beh_change && new_beh == ucrc_pkg::BEH_REPORT_DISC
                        && state.limit_reached_flag && !go_clear && !go_disable))
        begin
            next_state.sw_block   = 1'b0;
            next_state.emu_remove = 1'b0;
            next_state.sleep      = 1'b0;
            next_state.restart    = ctl.changed && EMULATION_ENABLE;
        end
    end

    assign ctl.latch = do_latch;

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state <= '{bus: ucrc_pkg::UCRC_IDLE, rdata: 32'h0000_0000,
                       limit_feature_enable: 1'b0,
                       limit_behavior_sel: ucrc_pkg::BEH_RESET,
                       limit: ucrc_pkg::LIMIT_RESET, accum: 32'h0000_0000,
                       limit_reached_flag: 1'b0, alert: 1'b0, sw_block: 1'b0,
                       emu_remove: 1'b0, sleep: 1'b0, restart: 1'b0, removed: 1'b0};
        end
        else
        begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign AVS_READDATA      = state.rdata;
    assign AVS_WAITREQUEST   = (AVS_READ || AVS_WRITE) && (state.bus == ucrc_pkg::UCRC_IDLE);
    assign AVS_RESPONSE      = 2'h0;
    assign ALERT_N           = !(state.alert || OTHER_ALERT);
    // Report-and-disconnect holds both switches open until a clear, a disable or a behaviour change re-evaluates.
    assign PORT_SWITCH_BLOCK = state.sw_block;
    assign BYPASS_BLOCK      = state.sw_block;
    assign EMULATION_REMOVE  = state.emu_remove;
    assign EMULATION_RESTART = state.restart;
    assign SLEEP_REQUEST     = state.sleep;
    // In sleep, control pin changes are ignored by the power manager.
    assign CONTROLS_FROZEN   = state.sleep;

endmodule : ucrc_ctrl

// *** pkg/ucrc_pkg.sv ***
package ucrc_pkg;

    // Behaviour field encoding.
    localparam logic [1:0] BEH_REPORT     = 2'h0;
    localparam logic [1:0] BEH_REPORT_DISC = 2'h1;
    localparam logic [1:0] BEH_DISC_SLEEP = 2'h2;
    localparam logic [1:0] BEH_IGNORE     = 2'h3;
    localparam logic [1:0] BEH_RESET      = 2'h1;

    localparam int ACC_W = 32;

    // Register byte addresses.
    localparam logic [3:0] ADDR_CTRL   = 4'h0;
    localparam logic [3:0] ADDR_LIMIT  = 4'h4;
    localparam logic [3:0] ADDR_ACCUM  = 4'h8;
    localparam logic [3:0] ADDR_STATUS = 4'hC;

    // Control register fields.
    localparam int CTRL_EN_BIT    = 0;
    localparam int CTRL_CLR_BIT   = 1;
    localparam int CTRL_BEH_LSB   = 4;
    localparam int CTRL_INC_BIT   = 8;

    // Status register fields.
    localparam int ST_FLAG_BIT    = 0;
    localparam int ST_ALERT_BIT   = 1;
    localparam int ST_SWITCH_BIT  = 2;
    localparam int ST_SLEEP_BIT   = 3;
    localparam int ST_EMU_BIT     = 4;

    localparam logic [31:0] LIMIT_RESET = 32'hFFFF_FFFF;

    typedef enum logic [1:0] {UCRC_IDLE, UCRC_ACK} ucrc_bus_e;

endpackage : ucrc_pkg

// *** pkg/ucrc_ctl_if.sv ***
`timescale 1ns/1ps
interface ucrc_ctl_if;
    logic [4:0] pins;
    logic       latch;
    logic       changed;
    modport owner (input pins, input latch, output changed);
    modport user  (output pins, output latch, input changed);
endinterface : ucrc_ctl_if

// *** src/ucrc_pin_snap.sv ***
`timescale 1ns/1ps
module ucrc_pin_snap
(
    // Clock and reset.
    input  wire logic CLOCK,
    input  wire logic ARST_N,
    // Snapshot port.
    ucrc_ctl_if.owner ctl
);
    // Holds the control pins seen when the limit was reached.
    typedef struct packed
    {
        logic [4:0] snap;
    } ucrc_snap_s;

    ucrc_snap_s state;
    ucrc_snap_s next_state;

    always_comb
    begin
        next_state = state;
        if (ctl.latch)
        begin
            next_state.snap = ctl.pins;
        end
    end

    assign ctl.changed = (ctl.pins != state.snap);

    always_ff @(posedge CLOCK or negedge ARST_N)
    begin
        if (!ARST_N)
        begin
            state <= '0;
        end
        else
        begin
            state <= next_state;
        end
    end
endmodule : ucrc_pin_snap

// *** sim/ucrc_chk_assertions.sv ***
`timescale 1ns/1ps
module ucrc_chk
(
    // Clock and reset.
    input wire logic CLOCK,
    input wire logic ARST_N,
    // Watched inputs.
    input wire logic AVS_WRITE,
    input wire logic OTHER_ALERT,
    input wire logic EMULATION_ENABLE,
    // Watched actions.
    input wire logic ALERT_N,
    input wire logic PORT_SWITCH_BLOCK,
    input wire logic BYPASS_BLOCK,
    input wire logic EMULATION_REMOVE,
    input wire logic EMULATION_RESTART,
    input wire logic SLEEP_REQUEST,
    input wire logic CONTROLS_FROZEN
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!ARST_N);

    // Two quiet cycles of the frozen state with no register write.
    sequence s_quiet_frozen;
        (CONTROLS_FROZEN && !AVS_WRITE) [*2];
    endsequence
    property p_other_alert;
        OTHER_ALERT |-> !ALERT_N;
    endproperty
    property p_restart_pulse;
        EMULATION_RESTART |=> !EMULATION_RESTART;
    endproperty
    property p_restart_en;
        EMULATION_RESTART |-> $past(EMULATION_ENABLE);
    endproperty
    property p_sleep_blocks;
        SLEEP_REQUEST |-> PORT_SWITCH_BLOCK && EMULATION_REMOVE;
    endproperty
    property p_sleep_frozen;
        SLEEP_REQUEST |-> CONTROLS_FROZEN;
    endproperty
    property p_frozen_stable;
        s_quiet_frozen |=> $stable(SLEEP_REQUEST) && $stable(PORT_SWITCH_BLOCK);
    endproperty
    property p_frozen_quiet;
        s_quiet_frozen |-> !EMULATION_RESTART;
    endproperty
    property p_bypass;
        BYPASS_BLOCK |-> PORT_SWITCH_BLOCK;
    endproperty

    a_other_alert:   assert property (p_other_alert)   else $error("alert not held");
    a_restart_pulse: assert property (p_restart_pulse) else $error("restart too long");
    a_restart_en:    assert property (p_restart_en)    else $error("restart not enabled");
    a_sleep_blocks:  assert property (p_sleep_blocks)  else $error("sleep, switch closed");
    a_sleep_frozen:  assert property (p_sleep_frozen)  else $error("sleep, controls live");
    a_frozen_stable: assert property (p_frozen_stable) else $error("frozen state moved");
    a_frozen_quiet:  assert property (p_frozen_quiet)  else $error("restart while frozen");
    a_bypass:        assert property (p_bypass)        else $error("bypass blocked alone");
endmodule : ucrc_chk

bind ucrc_ctrl ucrc_chk i_ucrc_chk (.CLOCK(CLOCK), .ARST_N(ARST_N), .AVS_WRITE(AVS_WRITE),
    .OTHER_ALERT(OTHER_ALERT), .EMULATION_ENABLE(EMULATION_ENABLE), .ALERT_N(ALERT_N),
    .PORT_SWITCH_BLOCK(PORT_SWITCH_BLOCK), .BYPASS_BLOCK(BYPASS_BLOCK),
    .EMULATION_REMOVE(EMULATION_REMOVE), .EMULATION_RESTART(EMULATION_RESTART),
    .SLEEP_REQUEST(SLEEP_REQUEST), .CONTROLS_FROZEN(CONTROLS_FROZEN));

// *** sim/ucrc_host_model.sv ***
`timescale 1ns/1ps
module ucrc_host_model
(
    // Clock.
    input  wire logic       clock,
    // Requested levels: mode high, mode low, emulation, gate, power.
    input  wire logic [4:0] req,
    // Control pins.
    output logic      [4:0] pins
);
    // The host moves its control levels just after an edge.
    always_ff @(posedge clock)
        pins <= req;
endmodule : ucrc_host_model

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic        rd = 1'b0;
    logic        wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic [31:0] q;
    logic        wait_req;
    logic [1:0]  resp;
    logic        bypass;
    logic        active = 1'b0;
    logic        tick = 1'b0;
    logic [15:0] amount = 16'h0000;
    logic        removal = 1'b0;
    logic        attach = 1'b0;
    logic        other = 1'b0;
    logic [4:0]  req = 5'h1D;
    logic [4:0]  pins;
    logic [4:0]  outs;
    logic        alert_n, sw_block, emu_rm, sleep_rq, restart, frozen;
    int          num_errors = 0;
    int          tests_run = 0;
    int          restarts = 0;
    int          cycles = 0;

    assign outs = {alert_n, sw_block, emu_rm, sleep_rq, frozen};

    ucrc_host_model i_ucrc_host_model (.clock(clk), .req(req), .pins(pins));

    ucrc_ctrl i_ucrc_ctrl (.CLOCK(clk), .ARST_N(arst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wait_req), .AVS_RESPONSE(resp), .ACTIVE_STATE(active),
        .CHARGE_TICK(tick), .CHARGE_AMOUNT(amount), .REMOVAL_EVENT(removal),
        .ATTACH_EVENT(attach), .OTHER_ALERT(other), .MODE_SELECT_HI(pins[4]),
        .MODE_SELECT_LO(pins[3]), .EMULATION_ENABLE(pins[2]), .ATTACH_GATE_SELECT(pins[1]),
        .PORT_POWER_ENABLE(pins[0]), .ALERT_N(alert_n), .PORT_SWITCH_BLOCK(sw_block),
        .BYPASS_BLOCK(bypass), .EMULATION_REMOVE(emu_rm), .EMULATION_RESTART(restart),
        .SLEEP_REQUEST(sleep_rq), .CONTROLS_FROZEN(frozen));

    always #12.5 clk = ~clk;

    always @(posedge clk)
    begin
        cycles++;
        if (restart === 1'b1) restarts++;
        if (cycles == 20000)
        begin
            num_errors++;
            final_report();
        end
    end

    task final_report;
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : final_report

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wr    <= w;
        rd    <= !w;
        wdata <= d;
        do @(posedge clk); while (wait_req !== 1'b0);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    task ctl(input logic [1:0] beh, input logic en, input logic clr);
        bus(1'b1, ucrc_pkg::ADDR_CTRL, (32'(beh) << ucrc_pkg::CTRL_BEH_LSB)
            | (32'(clr) << ucrc_pkg::CTRL_CLR_BIT) | 32'(en));
        repeat (3) @(posedge clk);
    endtask : ctl

    task give(input logic [15:0] a);
        @(posedge clk);
        tick   <= 1'b1;
        amount <= a;
        @(posedge clk);
        tick <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : give

    task pulse(input logic rem);
        @(posedge clk);
        removal <= rem;
        attach  <= !rem;
        @(posedge clk);
        removal <= 1'b0;
        attach  <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : pulse

    task reach(input logic [1:0] beh);
        bus(1'b1, ucrc_pkg::ADDR_LIMIT, 32'h0000_0064);
        ctl(beh, 1'b1, 1'b1);
        give(16'h003C);
        give(16'h0028);
    endtask : reach

    // Expected {alert_n, switch block, emulation removed, sleep, frozen}.
    function automatic logic [4:0] beh_outs(input logic [1:0] beh);
        case (beh)
            ucrc_pkg::BEH_REPORT:      return 5'h00;
            ucrc_pkg::BEH_REPORT_DISC: return 5'h0C;
            ucrc_pkg::BEH_DISC_SLEEP:  return 5'h1F;
            default:                   return 5'h10;
        endcase
    endfunction : beh_outs

    task t_reset;
        bus(1'b0, ucrc_pkg::ADDR_CTRL, 32'h0000_0000);
        chk("ctrl", q, 32'h0000_0010);
        bus(1'b0, ucrc_pkg::ADDR_LIMIT, 32'h0000_0000);
        chk("limit", q, ucrc_pkg::LIMIT_RESET);
        bus(1'b0, ucrc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("status", q, 32'h0000_0000);
        bus(1'b0, 4'h1, 32'h0000_0000);
        chk("unmapped", q, 32'h0000_0000);
        chk("response", resp, 32'h0000_0000);
        chk("outs", outs, 32'h0000_0010);
        $display("test reset done");
    endtask : t_reset

    task t_below;
        int r;
        reach(ucrc_pkg::BEH_REPORT_DISC);
        bus(1'b0, ucrc_pkg::ADDR_ACCUM, 32'h0000_0000);
        chk("idle accum", q, 32'h0000_0000);
        @(posedge clk);
        active <= 1'b1;
        give(16'h0028);
        ctl(ucrc_pkg::BEH_IGNORE, 1'b1, 1'b0);
        bus(1'b0, ucrc_pkg::ADDR_ACCUM, 32'h0000_0000);
        chk("accum", q, 32'h0000_0028);
        chk("outs", outs, 32'h0000_0010);
        r = restarts;
        pulse(1'b1);
        pulse(1'b0);
        bus(1'b0, ucrc_pkg::ADDR_ACCUM, 32'h0000_0000);
        chk("event accum", q, 32'h0000_0028);
        chk("restart", 32'(restarts > r), 32'h0000_0001);
        r = restarts;
        pulse(1'b0);
        chk("lone attach", 32'(restarts), 32'(r));
        ctl(ucrc_pkg::BEH_IGNORE, 1'b1, 1'b1);
        give(16'h001E);
        bus(1'b0, ucrc_pkg::ADDR_ACCUM, 32'h0000_0000);
        chk("cleared accum", q, 32'h0000_001E);
        ctl(ucrc_pkg::BEH_IGNORE, 1'b0, 1'b0);
        bus(1'b0, ucrc_pkg::ADDR_ACCUM, 32'h0000_0000);
        chk("disabled accum", q, 32'h0000_0000);
        $display("test below done");
    endtask : t_below

    task t_limit;
        logic [4:0] exp_outs;
        static logic [1:0] bs [12] = '{2'h0, 2'h2, 2'h3, 2'h0, 2'h3, 2'h1,
                                2'h2, 2'h1, 2'h3, 2'h2, 2'h0, 2'h1};
        reach(ucrc_pkg::BEH_REPORT_DISC);
        bus(1'b0, ucrc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("flag", q[0], 32'h0000_0001);
        chk("limit outs", outs, beh_outs(ucrc_pkg::BEH_REPORT_DISC));
        @(posedge clk);
        req <= req ^ 5'h10;
        repeat (3) @(posedge clk);
        chk("moved outs", outs, beh_outs(ucrc_pkg::BEH_REPORT_DISC));
        chk("bypass", bypass, 32'h0000_0001);
        for (int i = 0; i < 12; i++)
        begin
            ctl(bs[i], 1'b1, 1'b0);
            // Report to report-and-disconnect opens the switch but keeps emulation.
            exp_outs = (i == 11) ? 5'h08 : beh_outs(bs[i]);
            chk("change outs", outs, exp_outs);
        end
        bus(1'b0, ucrc_pkg::ADDR_ACCUM, 32'h0000_0000);
        chk("held accum", q, 32'h0000_0064);
        ctl(ucrc_pkg::BEH_REPORT_DISC, 1'b1, 1'b1);
        bus(1'b0, ucrc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("reset flag", q[0], 32'h0000_0000);
        chk("reset outs", outs, 32'h0000_0010);
        $display("test limit done");
    endtask : t_limit

    task t_disable;
        reach(ucrc_pkg::BEH_REPORT);
        @(posedge clk);
        other <= 1'b1;
        ctl(ucrc_pkg::BEH_REPORT, 1'b0, 1'b0);
        bus(1'b0, ucrc_pkg::ADDR_STATUS, 32'h0000_0000);
        chk("off flag", q[0], 32'h0000_0000);
        chk("other alert", alert_n, 32'h0000_0000);
        @(posedge clk);
        other <= 1'b0;
        @(posedge clk);
        chk("alert off", alert_n, 32'h0000_0001);
        reach(ucrc_pkg::BEH_REPORT_DISC);
        ctl(ucrc_pkg::BEH_REPORT_DISC, 1'b0, 1'b0);
        chk("off outs", outs[4:3], 32'h0000_0002);
        @(posedge clk);
        req <= req ^ 5'h01;
        repeat (3) @(posedge clk);
        req <= req ^ 5'h01;
        $display("test disable done");
    endtask : t_disable

    task t_reeval;
        int r;
        reach(ucrc_pkg::BEH_REPORT_DISC);
        r = restarts;
        ctl(ucrc_pkg::BEH_REPORT_DISC, 1'b1, 1'b1);
        chk("same pins", 32'(restarts), 32'(r));
        reach(ucrc_pkg::BEH_REPORT_DISC);
        @(posedge clk);
        req <= req ^ 5'h08;
        ctl(ucrc_pkg::BEH_REPORT_DISC, 1'b1, 1'b1);
        chk("new pins", 32'(restarts > r), 32'h0000_0001);
        $display("test reeval done");
    endtask : t_reeval

    initial
    begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        t_reset();
        t_below();
        t_limit();
        t_disable();
        t_reeval();
        final_report();
    end
endmodule : tb_top
